// >>> rtl/spipt_port.sv
`timescale 1ns/1ps
`include "spipt_regs.svh"

// How it works
// - Master drives chip select low for a byte, high once it ends.
// - Bit 11 high while receive fill exceeds the threshold count.
// - Bits 10:8 give receive fill level, zero to four bytes.
// - Bit 7 set when a byte arrives with receive FIFO full.
// - Receive overflow raises the port interrupt unless receive flush set.
// - Reading status clears bits 7, 6, 5 and 4.
// - Bit 6 set when receive mode sees the threshold count received.
// - Bit 5 set when transmit mode has sent the threshold count.
// - Bit 4 set when a byte starts with transmit FIFO empty.
// - Transmit underflow raises the interrupt unless transmit flush set.
// - Bits 3:1 give transmit fill level, zero to four bytes.
// - Bit 0 set on any port interrupt, cleared by status read.
// - Status is read-only 32 bits at 0xFFFF0A00, resets zero.
// - Received bytes read from 8-bit register at 0xFFFF0A04.
// - Bytes to send written to 8-bit register at 0xFFFF0A08.
// - Six-bit divider at 0xFFFF0A0C, reset zero, maximum 0x3F.
// - Sixteen-bit control at 0xFFFF0A10, reset zero.
// - Master bit clock is clock over two times one plus divider.
// - Eight-bit bytes, most significant bit first on both lines.
// - Threshold codes 00 to 11 select one to four bytes.
module spipt_port
    import spipt_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Register access
    input wire logic [31:0] mmr_addr,
    input wire logic mmr_wr,
    input wire logic mmr_rd,
    input wire logic [31:0] mmr_wdata,
    output logic [31:0] mmr_rdata,
    // Serial clock pin
    input wire logic sclk_in,
    output logic sclk_out,
    output logic sclk_oe,
    // Master out, slave in pin
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    // Master in, slave out pin
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe,
    // Chip select pin, active low
    input wire logic cs_n_in,
    output logic cs_n_out,
    output logic cs_n_oe,
    // Interrupt request
    output logic irq_request
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [15:0] port_control;
    logic [5:0] bit_rate_divider;
    logic [7:0] receive_byte;
    logic rx_overflow_flag;
    logic rx_irq_flag;
    logic tx_irq_flag;
    logic tx_underflow_flag;
    logic port_irq_flag;
    logic [2:0] rx_fill_level;
    logic [2:0] tx_fill_level;
    logic rx_excess_flag;
    logic [1:0] irq_threshold;
    logic transfer_mode_select;
    logic rx_flush_control;
    logic tx_flush_control;
    logic port_en;
    logic is_master;
    logic cpol;
    spipt_state_type state;
    logic [5:0] div_cnt;
    logic tick;
    logic phase;
    logic [7:0] shreg;
    logic [2:0] bit_cnt;
    logic samp;
    logic din;
    logic need_load;
    logic start_pend;
    logic sclk_prev;
    logic sclk_norm;
    logic load_ev;
    logic sample_ev;
    logic shift_ev;
    logic byte_rx;
    logic byte_tx;
    logic [7:0] rx_word;
    logic [1:0] tx_done_cnt;
    logic rd_status;
    logic rd_rx;
    logic wr_tx;
    logic rx_full;
    logic rx_empty;
    logic tx_full;
    logic tx_empty;
    logic [7:0] rx_head;
    logic [7:0] tx_head;
    logic ovf_ev;
    logic udf_ev;
    logic rxirq_ev;
    logic txirq_ev;
    logic [31:0] status_word;

    // ----------------------------------------
    // Register decode and control fields
    // ----------------------------------------
    assign rd_status = mmr_rd & (mmr_addr == `SPIPT_ADDR_STATUS);
    assign rd_rx = mmr_rd & (mmr_addr == `SPIPT_ADDR_RX);
    assign wr_tx = mmr_wr & (mmr_addr == `SPIPT_ADDR_TX);
    assign port_en = port_control[`SPIPT_CTL_EN];
    assign is_master = port_control[`SPIPT_CTL_MASTER];
    assign cpol = port_control[`SPIPT_CTL_CPOL];
    assign transfer_mode_select = port_control[`SPIPT_CTL_TMODE];
    assign rx_flush_control = port_control[`SPIPT_CTL_RFLUSH];
    assign tx_flush_control = port_control[`SPIPT_CTL_TFLUSH];
    assign irq_threshold =
        port_control[`SPIPT_CTL_THR_HI:`SPIPT_CTL_THR_LO];

    // Software-written configuration
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            port_control <= `SPIPT_RST_CTL;
            bit_rate_divider <= `SPIPT_RST_DIV;
        end else if (mmr_wr) begin
            if (mmr_addr == `SPIPT_ADDR_CTL) begin
                port_control <= mmr_wdata[15:0];
            end
            if (mmr_addr == `SPIPT_ADDR_DIV) begin
                bit_rate_divider <= mmr_wdata[5:0];
            end
        end
    end

    // ----------------------------------------
    // Receive and transmit FIFOs
    // ----------------------------------------
    // Flush holds the FIFO empty; writes while flushing are lost
    spipt_fifo #(
        .WIDTH(8),
        .AW(2)
    ) u_rx_fifo (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .push(byte_rx),
        .pop(rd_rx),
        .flush(rx_flush_control),
        .wr_data(rx_word),
        .head(rx_head),
        .count(rx_fill_level),
        .full(rx_full),
        .empty(rx_empty)
    );

    spipt_fifo #(
        .WIDTH(8),
        .AW(2)
    ) u_tx_fifo (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .push(wr_tx),
        .pop(load_ev),
        .flush(tx_flush_control),
        .wr_data(mmr_wdata[7:0]),
        .head(tx_head),
        .count(tx_fill_level),
        .full(tx_full),
        .empty(tx_empty)
    );

    // ----------------------------------------
    // Bit clock divider
    // ----------------------------------------
    // Half period of 1 + divider clocks gives clk / (2 * (1 + div))
    assign tick = (state == SPIPT_SHIFT) &&
        (div_cnt == bit_rate_divider);

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            div_cnt <= '0;
        end else if (state != SPIPT_SHIFT || tick) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 1'b1;
        end
    end

    // ----------------------------------------
    // Shift event generation
    // ----------------------------------------
    // Slave clock is normalised by polarity so that mode 0 logic serves
    assign sclk_norm = sclk_in ^ cpol;
    assign din = is_master ? miso_in : mosi_in;

    always_comb begin
        load_ev = 1'b0;
        sample_ev = 1'b0;
        shift_ev = 1'b0;
        if (port_en && is_master) begin
            load_ev = (state == SPIPT_IDLE) && (transfer_mode_select ?
                !tx_empty : start_pend);
            sample_ev = tick & ~phase;
            shift_ev = tick & phase;
        end else if (port_en && !cs_n_in) begin
            load_ev = need_load;
            sample_ev = sclk_norm & ~sclk_prev;
            shift_ev = ~sclk_norm & sclk_prev;
        end
    end

    assign rx_word = {shreg[6:0], din};
    assign byte_rx = sample_ev & (bit_cnt == `SPIPT_LAST_BIT) &
        ~rx_flush_control;
    assign byte_tx = shift_ev & (bit_cnt == `SPIPT_LAST_BIT);

    // Previous slave clock level for edge detection
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sclk_prev <= 1'b0;
        end else begin
            sclk_prev <= sclk_norm;
        end
    end

    // Pending master start from a receive read in receive mode
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            start_pend <= 1'b0;
        end else if (!port_en || !is_master || transfer_mode_select) begin
            start_pend <= 1'b0;
        end else if (rd_rx) begin
            start_pend <= 1'b1;
        end else if (load_ev) begin
            start_pend <= 1'b0;
        end
    end

    // ----------------------------------------
    // Master sequencer
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state <= SPIPT_IDLE;
            phase <= 1'b0;
        end else if (!port_en || !is_master) begin
            state <= SPIPT_IDLE;
            phase <= 1'b0;
        end else begin
            case (state)
                SPIPT_IDLE: begin
                    phase <= 1'b0;
                    if (load_ev) begin
                        state <= SPIPT_SHIFT;
                    end
                end
                SPIPT_SHIFT: begin
                    if (tick) begin
                        phase <= ~phase;
                    end
                    if (byte_tx) begin
                        state <= SPIPT_IDLE;
                    end
                end
                default: begin
                    state <= SPIPT_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Shift register, MSB first
    // ----------------------------------------
    // Empty FIFO at load sends a filler byte
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            shreg <= '0;
            bit_cnt <= '0;
            samp <= 1'b0;
        end else if (!port_en || (!is_master && cs_n_in)) begin
            bit_cnt <= '0;
        end else if (load_ev) begin
            shreg <= tx_empty ? `SPIPT_IDLE_TX : tx_head;
            bit_cnt <= '0;
        end else begin
            if (sample_ev) begin
                samp <= din;
            end
            if (shift_ev) begin
                shreg <= {shreg[6:0], samp};
                bit_cnt <= bit_cnt + 1'b1;
            end
        end
    end

    // Slave reloads at select and after each full byte
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            need_load <= 1'b1;
        end else if (cs_n_in || byte_tx) begin
            need_load <= 1'b1;
        end else if (load_ev) begin
            need_load <= 1'b0;
        end
    end

    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    // Pins are released entirely while the port is disabled
    assign sclk_out = (phase ^ cpol) & (state == SPIPT_SHIFT);
    assign sclk_oe = port_en & is_master;
    assign mosi_out = shreg[7];
    assign mosi_oe = port_en & is_master;
    assign miso_out = shreg[7];
    assign miso_oe = port_en & ~is_master & ~cs_n_in;
    assign cs_n_out = (state != SPIPT_SHIFT);
    assign cs_n_oe = port_en & is_master;

    // ----------------------------------------
    // Status events
    // ----------------------------------------
    assign ovf_ev = byte_rx & rx_full;
    assign udf_ev = load_ev & tx_empty;
    // Threshold code n means n + 1 bytes
    assign rxirq_ev = byte_rx & ~transfer_mode_select &
        (rx_fill_level >= {1'b0, irq_threshold});
    assign txirq_ev = byte_tx & transfer_mode_select &
        (tx_done_cnt == irq_threshold);
    assign rx_excess_flag =
        (rx_fill_level > ({1'b0, irq_threshold} + 3'h1));

    // Bytes sent since the last transmit interrupt
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tx_done_cnt <= '0;
        end else if (!transfer_mode_select) begin
            tx_done_cnt <= '0;
        end else if (byte_tx) begin
            tx_done_cnt <= txirq_ev ? 2'h0 : tx_done_cnt + 1'b1;
        end
    end

    // ----------------------------------------
    // Sticky flags, cleared by status read
    // ----------------------------------------
    // A set in the read cycle wins so no event is lost
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rx_overflow_flag <= 1'b0;
            rx_irq_flag <= 1'b0;
            tx_irq_flag <= 1'b0;
            tx_underflow_flag <= 1'b0;
            port_irq_flag <= 1'b0;
        end else begin
            rx_overflow_flag <= ovf_ev |
                (rx_overflow_flag & ~rd_status);
            rx_irq_flag <= rxirq_ev |
                (rx_irq_flag & ~rd_status);
            tx_irq_flag <= txirq_ev |
                (tx_irq_flag & ~rd_status);
            tx_underflow_flag <= udf_ev |
                (tx_underflow_flag & ~rd_status);
            port_irq_flag <= (ovf_ev & ~rx_flush_control) |
                (udf_ev & ~tx_flush_control) |
                rxirq_ev | txirq_ev |
                (port_irq_flag & ~rd_status);
        end
    end

    assign irq_request = port_irq_flag;

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always_comb begin
        status_word = '0;
        status_word[`SPIPT_ST_EXCESS] = rx_excess_flag;
        status_word[`SPIPT_ST_RXLVL_HI:`SPIPT_ST_RXLVL_LO] =
            rx_fill_level;
        status_word[`SPIPT_ST_OVF] = rx_overflow_flag;
        status_word[`SPIPT_ST_RXIRQ] = rx_irq_flag;
        status_word[`SPIPT_ST_TXIRQ] = tx_irq_flag;
        status_word[`SPIPT_ST_UDF] = tx_underflow_flag;
        status_word[`SPIPT_ST_TXLVL_HI:`SPIPT_ST_TXLVL_LO] =
            tx_fill_level;
        status_word[`SPIPT_ST_IRQ] = port_irq_flag;
    end

    // Received byte register holds the last byte popped
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            receive_byte <= `SPIPT_RST_RX;
        end else if (rd_rx && !rx_empty && !rx_flush_control) begin
            receive_byte <= rx_head;
        end
    end

    // Registered answer, one cycle after the read strobe
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mmr_rdata <= '0;
        end else if (mmr_rd) begin
            case (mmr_addr)
                `SPIPT_ADDR_STATUS: mmr_rdata <= status_word;
                `SPIPT_ADDR_RX: begin
                    mmr_rdata <= (rx_empty || rx_flush_control) ?
                        {24'h0, receive_byte} : {24'h0, rx_head};
                end
                `SPIPT_ADDR_DIV: mmr_rdata <= {26'h0, bit_rate_divider};
                `SPIPT_ADDR_CTL: mmr_rdata <= {16'h0, port_control};
                default: mmr_rdata <= '0;
            endcase
        end
    end

    // Full transmit FIFO silently drops a write
    logic unused_tx_full;
    assign unused_tx_full = tx_full;
endmodule

// >>> rtl/spipt_regs.svh
`ifndef SPIPT_REGS_SVH
`define SPIPT_REGS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define SPIPT_ADDR_STATUS 32'hFFFF0A00
`define SPIPT_ADDR_RX 32'hFFFF0A04
`define SPIPT_ADDR_TX 32'hFFFF0A08
`define SPIPT_ADDR_DIV 32'hFFFF0A0C
`define SPIPT_ADDR_CTL 32'hFFFF0A10

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SPIPT_RST_RX 8'h00
`define SPIPT_RST_DIV 6'h00
`define SPIPT_RST_CTL 16'h0000

// ----------------------------------------
// Status field positions
// ----------------------------------------
`define SPIPT_ST_EXCESS 11
`define SPIPT_ST_RXLVL_HI 10
`define SPIPT_ST_RXLVL_LO 8
`define SPIPT_ST_OVF 7
`define SPIPT_ST_RXIRQ 6
`define SPIPT_ST_TXIRQ 5
`define SPIPT_ST_UDF 4
`define SPIPT_ST_TXLVL_HI 3
`define SPIPT_ST_TXLVL_LO 1
`define SPIPT_ST_IRQ 0

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define SPIPT_CTL_EN 0
`define SPIPT_CTL_MASTER 1
`define SPIPT_CTL_CPOL 2
`define SPIPT_CTL_TMODE 6
`define SPIPT_CTL_RFLUSH 12
`define SPIPT_CTL_TFLUSH 13
`define SPIPT_CTL_THR_HI 15
`define SPIPT_CTL_THR_LO 14

// ----------------------------------------
// Shift engine constants
// ----------------------------------------
`define SPIPT_LAST_BIT 3'h7
`define SPIPT_IDLE_TX 8'h00

`endif

// >>> rtl/spipt_pkg.sv
package spipt_pkg;

    // Master sequencer states
    typedef enum logic [0:0] {
        SPIPT_IDLE = 1'b0,
        SPIPT_SHIFT = 1'b1
    } spipt_state_type;

endpackage

// >>> rtl/spipt_fifo.sv
`timescale 1ns/1ps

// ----------------------------------------
// Small byte FIFO with fill count
// ----------------------------------------
module spipt_fifo #(
    parameter int WIDTH = 8,
    parameter int AW = 2
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Control
    input wire logic push,
    input wire logic pop,
    input wire logic flush,
    input wire logic [WIDTH-1:0] wr_data,
    // State
    output logic [WIDTH-1:0] head,
    output logic [AW:0] count,
    output logic full,
    output logic empty
);
    logic [WIDTH-1:0] mem [2**AW];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic do_push;
    logic do_pop;

    // Pushes into a full FIFO are dropped; only the receive caller flags them
    assign full = (count == (AW+1)'(2**AW));
    assign empty = (count == '0);
    assign do_push = push & ~full & ~flush;
    assign do_pop = pop & ~empty & ~flush;
    assign head = mem[rd_ptr];

    // Storage
    always_ff @(posedge clk_sys) begin
        if (do_push) begin
            mem[wr_ptr] <= wr_data;
        end
    end

    // Pointers and count
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_push && !do_pop) begin
                count <= count + 1'b1;
            end else if (do_pop && !do_push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// >>> verification/spipt_port_props.sv
`timescale 1ns/1ps
`include "spipt_regs.svh"

// ------
// Port checker
// ------
module spipt_port_props (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Register access
    input wire logic [31:0] mmr_addr,
    input wire logic mmr_rd,
    input wire logic [31:0] mmr_rdata,
    // Pins and request
    input wire logic mosi_oe,
    input wire logic cs_n_out,
    input wire logic cs_n_oe,
    input wire logic irq_request
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Status and receive read strobes, decoded once
    wire st_rd = mmr_rd && mmr_addr == `SPIPT_ADDR_STATUS;
    wire rx_rd = mmr_rd && mmr_addr == `SPIPT_ADDR_RX;

    rdata_hold_a: assert property (!mmr_rd |=> $stable(mmr_rdata))
        else $error("read data moved without a read");
    irq_report_a: assert property (st_rd |=>
        mmr_rdata[0] == $past(irq_request))
        else $error("status bit 0 differs from request line");
    reserved_zero_a: assert property (st_rd |=>
        mmr_rdata[31:12] == 20'h00000)
        else $error("reserved status bits set");
    fill_range_a: assert property (st_rd |=>
        mmr_rdata[10:8] <= 3'h4 && mmr_rdata[3:1] <= 3'h4)
        else $error("fill level above four");
    excess_fill_a: assert property (st_rd ##1 mmr_rdata[11] |->
        mmr_rdata[10:8] >= 3'h2)
        else $error("excess flag with too few bytes");
    rx_narrow_a: assert property (rx_rd |=>
        mmr_rdata[31:8] == 24'h000000)
        else $error("receive read wider than a byte");
    cs_drive_a: assert property (!cs_n_out |-> cs_n_oe && mosi_oe)
        else $error("select low while pins not driven");
    byte_min_a: assert property ($fell(cs_n_out) |-> !cs_n_out [*8])
        else $error("select released inside a byte");

    // Main scenarios reached
    cover property (st_rd ##1 mmr_rdata[7]);
    cover property (st_rd ##1 mmr_rdata[4]);
    cover property ($fell(cs_n_out));
endmodule

bind spipt_port spipt_port_props u_spipt_port_props (
    .clk_sys(clk_sys), .reset_n(reset_n), .mmr_addr(mmr_addr),
    .mmr_rd(mmr_rd), .mmr_rdata(mmr_rdata), .mosi_oe(mosi_oe),
    .cs_n_out(cs_n_out), .cs_n_oe(cs_n_oe), .irq_request(irq_request)
);

// >>> verification/spipt_slave_model.sv
`timescale 1ns/1ps

// ------
// External slave on the link
// ------
module spipt_slave_model (
    // Serial pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso
);
    logic [7:0] got[$];
    logic [7:0] tx_sh;
    logic [7:0] rx_sh;
    int n_bits = 0;
    // Reply is C0 plus byte count, so the bench can predict it
    always @(negedge cs_n) begin
        tx_sh = 8'hC0 + 8'(got.size());
        miso = tx_sh[7];
        n_bits = 0;
    end
    // Released line does not keep the last bit
    always @(posedge cs_n) begin
        miso = ~miso;
    end
    // Sample on rising edge, most significant bit first
    always @(posedge sclk) begin
        if (!cs_n) begin
            rx_sh = {rx_sh[6:0], mosi};
            n_bits++;
            if (n_bits == 8) begin
                got.push_back(rx_sh);
            end
        end
    end
    // Next bit out on falling edge
    always @(negedge sclk) begin
        if (!cs_n) begin
            tx_sh = {tx_sh[6:0], 1'b0};
            miso = tx_sh[7];
        end
    end
endmodule

// >>> verification/tb_spipt_port.sv
`timescale 1ns/1ps
`include "spipt_regs.svh"

// ------
// Port bench
// ------
module tb_spipt_port;
    logic clk_sys, reset_n, mmr_wr, mmr_rd, irq_request, slave_miso;
    logic [31:0] mmr_addr, mmr_wdata, mmr_rdata, d;
    logic sclk_out, sclk_oe, mosi_out, mosi_oe, miso_out, miso_oe;
    logic cs_n_out, cs_n_oe;
    logic m_cs_n, m_sclk, m_mosi;
    logic [7:0] sb;
    int n_errors = 0;
    int n_checks = 0;
    int lo;
    // Wire levels: the port drives, else the outside master, or the slave model on miso
    wire sclk_w = sclk_oe ? sclk_out : m_sclk;
    wire mosi_w = mosi_oe ? mosi_out : m_mosi;
    wire miso_w = miso_oe ? miso_out : slave_miso;
    wire cs_n_w = cs_n_oe ? cs_n_out : m_cs_n;

    spipt_port u_spipt_port (
        .clk_sys(clk_sys), .reset_n(reset_n), .mmr_addr(mmr_addr),
        .mmr_wr(mmr_wr), .mmr_rd(mmr_rd), .mmr_wdata(mmr_wdata),
        .mmr_rdata(mmr_rdata), .sclk_in(sclk_w), .sclk_out(sclk_out),
        .sclk_oe(sclk_oe), .mosi_in(mosi_w), .mosi_out(mosi_out),
        .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out),
        .miso_oe(miso_oe), .cs_n_in(cs_n_w), .cs_n_out(cs_n_out),
        .cs_n_oe(cs_n_oe), .irq_request(irq_request)
    );
    spipt_slave_model u_spipt_slave_model (
        .sclk(sclk_w), .cs_n(cs_n_w), .mosi(mosi_w), .miso(slave_miso)
    );

    // 20 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic summarize();
        if (n_errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // One-cycle strobes, launched off the falling edge
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        @(negedge clk_sys);
        mmr_addr = a;
        mmr_wdata = v;
        mmr_wr = 1'b1;
        @(negedge clk_sys);
        mmr_wr = 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] v);
        @(negedge clk_sys);
        mmr_addr = a;
        mmr_rd = 1'b1;
        @(negedge clk_sys);
        mmr_rd = 1'b0;
        v = mmr_rdata;
    endtask
    task automatic rc(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        chk(v, exp);
    endtask
    task automatic rs(input logic [31:0] exp);
        rc(`SPIPT_ADDR_STATUS, exp);
    endtask
    task automatic chk_got(input int i, input logic [7:0] exp);
        chk(32'(u_spipt_slave_model.got[i]), 32'(exp));
    endtask
    // Wait until the link is quiet; count select-low cycles
    task automatic wait_idle(output int low);
        int quiet;
        low = 0;
        quiet = 0;
        for (int i = 0; i < 3000 && (low == 0 || quiet < 8); i++) begin
            @(negedge clk_sys);
            if (cs_n_w === 1'b0) begin
                low++;
                quiet = 0;
            end else begin
                quiet++;
            end
        end
        if (low == 0 || quiet < 8) begin
            n_errors++;
            $display("mismatch at %0t: link never went quiet", $time);
            summarize();
        end
    endtask
    // Outside master clocks one byte in slave mode, mode 0
    task automatic xfer(input logic [7:0] o, output logic [7:0] r);
        m_cs_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        for (int i = 7; i >= 0; i--) begin
            m_mosi = o[i];
            repeat (3) @(negedge clk_sys);
            m_sclk = 1'b1;
            r[i] = miso_w;
            repeat (3) @(negedge clk_sys);
            m_sclk = 1'b0;
        end
        @(negedge clk_sys);
        m_cs_n = 1'b1;
    endtask

    // Main sequence
    initial begin
        reset_n = 1'b0;
        m_cs_n = 1'b1;
        m_sclk = 1'b0;
        m_mosi = 1'b0;
        mmr_addr = 32'h0;
        mmr_wdata = 32'h0;
        mmr_wr = 1'b0;
        mmr_rd = 1'b0;
        repeat (6) @(negedge clk_sys);
        reset_n = 1'b1;
        rs(32'h0);
        rc(`SPIPT_ADDR_RX, 32'h0);
        rc(`SPIPT_ADDR_DIV, 32'h0);
        rc(`SPIPT_ADDR_CTL, 32'h0);
        rc(32'hFFFF0A14, 32'h0);
        // Width of writable places; status ignores writes
        wr(`SPIPT_ADDR_DIV, 32'hFFFFFFFF);
        rc(`SPIPT_ADDR_DIV, 32'h3F);
        wr(`SPIPT_ADDR_CTL, 32'hFFFF0001);
        rc(`SPIPT_ADDR_CTL, 32'h1);
        wr(`SPIPT_ADDR_STATUS, 32'hFFFFFFFF);
        rs(32'h0);
        // Slave with select high: queue fills, fifth byte refused
        for (int i = 1; i <= 5; i++) begin
            wr(`SPIPT_ADDR_TX, 32'(i * 8'h11));
        end
        rs(32'h8);
        // Master, transmit mode, one-byte threshold, fastest rate
        wr(`SPIPT_ADDR_DIV, 32'h0);
        wr(`SPIPT_ADDR_CTL, 32'h43);
        wait_idle(lo);
        chk(32'(lo), 32'h40);
        chk(32'(u_spipt_slave_model.got.size()), 32'h4);
        for (int i = 0; i < 4; i++) begin
            chk_got(i, 8'((i + 1) * 8'h11));
        end
        chk(32'(irq_request), 32'h1);
        rs(32'hC21);
        chk(32'(irq_request), 32'h0);
        rs(32'hC00);
        for (int i = 0; i < 4; i++) begin
            rc(`SPIPT_ADDR_RX, 32'hC0 + 32'(i));
        end
        rs(32'h0);
        // Fifth received byte meets a full receive queue
        for (int i = 0; i < 4; i++) begin
            wr(`SPIPT_ADDR_TX, 32'hA0 + 32'(i));
        end
        wait_idle(lo);
        wr(`SPIPT_ADDR_TX, 32'hA4);
        wait_idle(lo);
        rs(32'hCA1);
        // Receive flush empties the queue and drops new bytes
        wr(`SPIPT_ADDR_CTL, 32'h1043);
        wr(`SPIPT_ADDR_TX, 32'hA5);
        wait_idle(lo);
        rd(`SPIPT_ADDR_STATUS, d);
        chk(d & 32'hF80, 32'h0);
        // Receive mode, halved rate; a receive read starts a byte
        wr(`SPIPT_ADDR_CTL, 32'h3);
        wr(`SPIPT_ADDR_DIV, 32'h1);
        rd(`SPIPT_ADDR_RX, d);
        wait_idle(lo);
        chk(32'(lo), 32'h20);
        chk_got(10, 8'h00);
        rs(32'h151);
        rc(`SPIPT_ADDR_RX, 32'hCA);
        wait_idle(lo);
        // Transmit flush keeps underflow off the request line
        wr(`SPIPT_ADDR_CTL, 32'h3003);
        rs(32'h51);
        rd(`SPIPT_ADDR_RX, d);
        wait_idle(lo);
        rs(32'h10);
        // Two-byte threshold: transmit interrupt every second byte
        wr(`SPIPT_ADDR_CTL, 32'h4043);
        wr(`SPIPT_ADDR_TX, 32'hB0);
        wait_idle(lo);
        rs(32'h100);
        wr(`SPIPT_ADDR_TX, 32'hB1);
        wait_idle(lo);
        rs(32'h221);
        rc(`SPIPT_ADDR_RX, 32'hCD);
        rc(`SPIPT_ADDR_RX, 32'hCE);
        // Slave mode: one byte each way under an outside clock
        wr(`SPIPT_ADDR_CTL, 32'h41);
        wr(`SPIPT_ADDR_TX, 32'h5A);
        xfer(8'hC3, sb);
        chk(32'(sb), 32'h5A);
        rs(32'h121);
        rc(`SPIPT_ADDR_RX, 32'hC3);
        summarize();
    end
endmodule
